// *** clock_output_control_pkg.sv ***
// Constants, register map and types for the clock output control block.
// Assumes an APB master on pclk; pins are synchronous to pclk.
// Functional notes
// - reference_select 0 picks pair A, 1 pair B
// - feedback_select 0 picks pair A, 1 pair B
// - lock output low while locked, else high
// - gated bank passes clock only while gate high
// - gate changes never truncate an output pulse
// - per-output enable: on, off, enable x, enable y
// - global disable high tristates every output
// - global disable also kills feedback, lock lost
// - two profile pins pick one of four profiles
// - bypass low uses oscillator, high input divider
// - reset pin clears counters and reports unlock
// - each bank picks divider and driver type
// - single-ended pairs: per-output impedance and slew
`default_nettype none
package clock_output_control_pkg;
  localparam int num_banks = 10;
  localparam int num_outputs = 20;
  localparam int num_dividers = 5;
  localparam int num_profiles = 4;
  localparam int lock_count_bits = 8;
  // Loop considered locked after this many agreeing cycles
  localparam logic [7:0] lock_count_max = 8'hff;

  // Register byte offsets
  localparam logic [11:0] off_bank_cfg = 12'h000;
  localparam logic [11:0] off_out_en_cfg = 12'h040;
  localparam logic [11:0] off_out_drv_cfg = 12'h080;
  // Dividers sit above the 20 output drive words; status outside all profile pages
  localparam logic [11:0] off_div_cfg = 12'h0e0;
  localparam logic [11:0] off_status = 12'h400;
  localparam logic [11:0] off_profile_sel = 12'h404;

  // Bank config fields: [2:0] divider, [5:3] driver type, [6] gate enable, [7] gate idle level
  localparam int bank_div_lsb = 0;
  localparam int bank_drv_lsb = 3;
  localparam int bank_gate_en_bit = 6;
  localparam int bank_idle_bit = 7;
  localparam logic [31:0] bank_cfg_reset = 32'h0000_0000;
  // Per-output drive fields: [3:0] impedance, [4] slew
  localparam logic [31:0] out_drv_reset = 32'h0000_0000;
  // Divider config: 5-bit ratio each
  localparam logic [4:0] div_reset = 5'h00;
  // Output enable mode per output, 2 bits each
  localparam logic [39:0] out_en_reset = 40'h00_0000_0000;

  typedef enum logic [1:0] {
    oe_always_on = 2'h0,
    oe_always_off = 2'h1,
    oe_by_x = 2'h2,
    oe_by_y = 2'h3
  } oe_mode_t;

  // Status bits
  localparam int st_lock_bit = 0;
  localparam int st_bypass_bit = 1;
  localparam int st_ref_sel_bit = 2;
  localparam int st_fbk_sel_bit = 3;
  localparam int st_gdis_bit = 4;
  localparam int st_profile_lsb = 5;
endpackage
`default_nettype wire

// *** clock_output_control.sv ***
// Digital control of a zero-delay clock generator: source selection,
// lock detect, output dividers, synchronous gating and output enables.
// Assumes clock inputs are already sampled as pclk-rate levels.
`timescale 1ns/1ps
`default_nettype none
module clock_output_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_pair_a,
  input wire logic reference_pair_b,
  input wire logic feedback_pair_a,
  input wire logic feedback_pair_b,
  input wire logic reference_select,
  input wire logic feedback_select,
  input wire logic oscillator_clk,
  input wire logic input_divider_clk,
  input wire logic bypass,
  input wire logic loop_reset,
  input wire logic sync_gate_input,
  input wire logic global_output_disable,
  input wire logic output_enable_x_n,
  input wire logic output_enable_y_n,
  input wire logic profile_select_bit0,
  input wire logic profile_select_bit1,
  input wire logic factory_test_input_1,
  input wire logic factory_test_input_2,
  output logic reference_clk,
  output logic feedback_clk,
  output logic feedback_buffer_en,
  output logic lock_n,
  output logic [1:0] active_profile,
  output logic [clock_output_control_pkg::num_outputs-1:0] clock_out,
  output logic [clock_output_control_pkg::num_outputs-1:0] clock_out_oe,
  output logic [clock_output_control_pkg::num_banks*3-1:0] bank_driver_type,
  output logic [clock_output_control_pkg::num_outputs*4-1:0] out_impedance,
  output logic [clock_output_control_pkg::num_outputs-1:0] out_slew
);
  import clock_output_control_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Profile storage, selected by pins; pins with pull-downs read low
  wire logic [1:0] profile_sel = {profile_select_bit1, profile_select_bit0};
  logic [31:0] bank_cfg_q [num_profiles][num_banks];
  logic [31:0] out_drv_q [num_profiles][num_outputs];
  logic [4:0] div_q [num_profiles][num_dividers];
  logic [39:0] out_en_q [num_profiles];

  // Factory test pins are assumed grounded and are not used
  wire logic test_unused = factory_test_input_1 | factory_test_input_2;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  assign reference_clk = reference_select ? reference_pair_b : reference_pair_a;
  assign feedback_clk = feedback_select ? feedback_pair_b : feedback_pair_a;
  assign feedback_buffer_en = ~global_output_disable;
  wire logic fb_eff = feedback_clk & feedback_buffer_en;
  wire logic div_src = bypass ? input_divider_clk : oscillator_clk;
  assign active_profile = profile_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Lock detect: reference and feedback edges agree for a full count
  logic ref_q, fb_q, lock_q;
  logic [lock_count_bits-1:0] lock_cnt_q;
  wire logic ref_rise = reference_clk & ~ref_q;
  wire logic fb_rise = fb_eff & ~fb_q;
  wire logic edge_miss = ref_rise ^ fb_rise;
  wire logic lock_hold = lock_cnt_q == lock_count_max;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
      fb_q <= 1'b0;
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end else begin
      ref_q <= reference_clk;
      fb_q <= fb_eff;
      if (loop_reset || global_output_disable || edge_miss) begin
        lock_cnt_q <= '0;
        lock_q <= 1'b0;
      end else begin
        if (ref_rise && !lock_hold) lock_cnt_q <= lock_cnt_q + 1'b1;
        lock_q <= lock_hold;
      end
    end
  end
  assign lock_n = ~lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output dividers, cleared by the reset pin
  logic src_q;
  wire logic src_rise = div_src & ~src_q;
  logic [4:0] div_cnt_q [num_dividers];
  logic [num_dividers-1:0] div_out_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) src_q <= 1'b0;
    else src_q <= div_src;
  end

  genvar gd;
  generate
    for (gd = 0; gd < num_dividers; gd++) begin : g_div
      wire logic [4:0] ratio = div_q[profile_sel][gd];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          div_cnt_q[gd] <= '0;
          div_out_q[gd] <= 1'b0;
        end else if (loop_reset) begin
          div_cnt_q[gd] <= '0;
          div_out_q[gd] <= 1'b0;
        end else if (src_rise) begin
          if (div_cnt_q[gd] >= ratio) begin
            div_cnt_q[gd] <= '0;
            div_out_q[gd] <= ~div_out_q[gd];
          end else begin
            div_cnt_q[gd] <= div_cnt_q[gd] + 5'h01;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank gating and outputs
  logic [num_banks-1:0] bank_clk_q, gate_s1_q, gate_s2_q, gate_on_q;
  wire logic [39:0] oe_cfg = out_en_q[profile_sel];

  genvar gb;
  generate
    for (gb = 0; gb < num_banks; gb++) begin : g_bank
      wire logic [31:0] cfg = bank_cfg_q[profile_sel][gb];
      wire logic [2:0] dsel = cfg[bank_div_lsb +: 3];
      wire logic div_clk = (dsel < 3'(num_dividers)) ? div_out_q[dsel] : 1'b0;
      wire logic gate_en = cfg[bank_gate_en_bit];
      wire logic idle_lvl = cfg[bank_idle_bit];
      wire logic at_idle = bank_clk_q[gb] == idle_lvl;
      // Switch only between pulses, so a divider pulse is never entered midway
      wire logic can_switch = at_idle && (div_clk == idle_lvl);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gate_s1_q[gb] <= 1'b0;
          gate_s2_q[gb] <= 1'b0;
          gate_on_q[gb] <= 1'b0;
          bank_clk_q[gb] <= 1'b0;
        end else begin
          gate_s1_q[gb] <= sync_gate_input;
          gate_s2_q[gb] <= gate_s1_q[gb];
          if (can_switch) gate_on_q[gb] <= gate_s2_q[gb] | ~gate_en;
          if (gate_on_q[gb] || !at_idle) bank_clk_q[gb] <= div_clk;
          else bank_clk_q[gb] <= idle_lvl;
        end
      end
      assign bank_driver_type[gb*3 +: 3] = cfg[bank_drv_lsb +: 3];
    end
  endgenerate

  genvar go;
  generate
    for (go = 0; go < num_outputs; go++) begin : g_out
      wire logic [1:0] mode = oe_cfg[go*2 +: 2];
      logic en;
      always_comb begin
        case (mode)
          oe_always_on: en = 1'b1;
          oe_always_off: en = 1'b0;
          oe_by_x: en = ~output_enable_x_n;
          oe_by_y: en = ~output_enable_y_n;
          default: en = 1'b0;
        endcase
      end
      assign clock_out[go] = bank_clk_q[go/2];
      assign clock_out_oe[go] = en & ~global_output_disable;
      assign out_impedance[go*4 +: 4] = out_drv_q[profile_sel][go][3:0];
      assign out_slew[go] = out_drv_q[profile_sel][go][4];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states; address bits [9:8] pick profile
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic [1:0] ap = paddr[9:8];
  wire logic [11:0] lo = {4'h0, paddr[7:0]} ;
  wire logic [11:0] pofs = {2'b00, paddr[9:8], 8'h00};
  wire logic [5:0] idx = paddr[7:2];
  wire logic in_prof = paddr[11:10] == 2'b00;
  wire logic hit_bank = in_prof && lo < off_out_en_cfg && idx < 6'(num_banks);
  wire logic hit_oe = in_prof && lo >= off_out_en_cfg && lo < off_out_en_cfg + 12'h008;
  wire logic hit_drv = in_prof && lo >= off_out_drv_cfg && lo < off_out_drv_cfg + 12'h050;
  wire logic [5:0] didx = 6'(({4'h0, paddr[7:0]} - off_out_drv_cfg) >> 2);
  wire logic hit_div = in_prof && lo >= off_div_cfg && lo < off_div_cfg + 12'h014;
  wire logic [5:0] vidx = 6'(({4'h0, paddr[7:0]} - off_div_cfg) >> 2);
  wire logic hit_st = paddr == off_status;
  wire logic hit_ps = paddr == off_profile_sel;
  wire logic hit_any = hit_bank | hit_oe | hit_drv | hit_div | hit_st | hit_ps;
  wire logic oe_hi = paddr[2];
  wire logic [31:0] status = {{(32-st_profile_lsb-2){1'b0}}, profile_sel, global_output_disable,
                              feedback_select, reference_select, bypass, lock_q};
  logic [31:0] rd;

  always_comb begin
    rd = 32'h0000_0000;
    if (hit_bank) rd = bank_cfg_q[ap][idx[3:0]];
    else if (hit_oe) rd = oe_hi ? {24'h00_0000, out_en_q[ap][39:32]} : out_en_q[ap][31:0];
    else if (hit_drv) rd = {27'h000_0000, out_drv_q[ap][didx[4:0]][4:0]};
    else if (hit_div) rd = {27'h000_0000, div_q[ap][vidx[2:0]]};
    else if (hit_st) rd = status;
    else if (hit_ps) rd = {30'h0000_0000, profile_sel};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      for (int p = 0; p < num_profiles; p++) begin
        out_en_q[p] <= out_en_reset;
        for (int b = 0; b < num_banks; b++) bank_cfg_q[p][b] <= bank_cfg_reset;
        for (int o = 0; o < num_outputs; o++) out_drv_q[p][o] <= out_drv_reset;
        for (int d = 0; d < num_dividers; d++) div_q[p][d] <= div_reset;
      end
    end else begin
      if (psel && !penable && !pwrite) prdata <= rd;
      if (wr && hit_bank) bank_cfg_q[ap][idx[3:0]] <= {24'h00_0000, pwdata[7:0]};
      if (wr && hit_oe && oe_hi) out_en_q[ap][39:32] <= pwdata[7:0];
      if (wr && hit_oe && !oe_hi) out_en_q[ap][31:0] <= pwdata;
      if (wr && hit_drv) out_drv_q[ap][didx[4:0]] <= {27'h000_0000, pwdata[4:0]};
      if (wr && hit_div) div_q[ap][vidx[2:0]] <= pwdata[4:0];
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  wire logic unused_ok = test_unused | (|pofs);
endmodule // clock_output_control
`default_nettype wire

// *** clock_output_control_props.sv ***
// Checker on the clock output control ports.
// Assumes one pclk domain, presetn async active low.
`timescale 1ns/1ps
`default_nettype none
module clock_output_control_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reference_pair_a,
  input wire logic reference_pair_b,
  input wire logic feedback_pair_a,
  input wire logic feedback_pair_b,
  input wire logic reference_select,
  input wire logic feedback_select,
  input wire logic loop_reset,
  input wire logic global_output_disable,
  input wire logic profile_select_bit0,
  input wire logic profile_select_bit1,
  input wire logic reference_clk,
  input wire logic feedback_clk,
  input wire logic feedback_buffer_en,
  input wire logic lock_n,
  input wire logic [1:0] active_profile,
  input wire logic [clock_output_control_pkg::num_outputs-1:0] clock_out_oe
);
  import clock_output_control_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  a_ref_mux: assert property (reference_clk == (reference_select ? reference_pair_b : reference_pair_a))
    else $error("reference mux wrong");
  a_fbk_mux: assert property (feedback_clk == (feedback_select ? feedback_pair_b : feedback_pair_a))
    else $error("feedback mux wrong");
  a_lock_cause: assert property ($fell(lock_n) |-> !$past(loop_reset) && !$past(global_output_disable))
    else $error("lock gained while cleared");
  a_gdis_tristate: assert property (global_output_disable |-> clock_out_oe == '0)
    else $error("output enabled under global disable");
  a_gdis_fbbuf: assert property (feedback_buffer_en == !global_output_disable)
    else $error("feedback buffer enable wrong");
  a_gdis_unlock: assert property (global_output_disable |=> lock_n)
    else $error("lock kept under global disable");
  a_profile_pick: assert property (active_profile == {profile_select_bit1, profile_select_bit0})
    else $error("profile select wrong");
  a_reset_unlock: assert property (loop_reset [*2] |-> lock_n)
    else $error("lock kept under loop reset");
endmodule // clock_output_control_props

bind clock_output_control clock_output_control_props props_u (.pclk, .presetn, .reference_pair_a,
  .reference_pair_b, .feedback_pair_a, .feedback_pair_b, .reference_select, .feedback_select, .loop_reset,
  .global_output_disable, .profile_select_bit0, .profile_select_bit1, .reference_clk, .feedback_clk,
  .feedback_buffer_en, .lock_n, .active_profile, .clock_out_oe);
`default_nettype wire

// *** clock_source_model.sv ***
// Reference, feedback and divider sources seen by the block.
// Assumes pclk; all sources are pclk-rate levels.
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic reference_pair_a,
  output logic reference_pair_b,
  output logic feedback_pair_a,
  output logic feedback_pair_b,
  output logic oscillator_clk,
  output logic input_divider_clk
);
  logic [2:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end
  // Pair a is phase aligned, pair b never agrees
  assign reference_pair_a = cnt_q[1];
  assign feedback_pair_a = cnt_q[1];
  assign reference_pair_b = cnt_q[2];
  assign feedback_pair_b = ~cnt_q[2];
  assign oscillator_clk = cnt_q[0];
  assign input_divider_clk = cnt_q[1];
endmodule // clock_source_model
`default_nettype wire

// *** clock_output_control_tb_top.sv ***
// Self-checking bench for the clock output control block.
// Assumes clock_source_model drives all clock inputs.
`timescale 1ns/1ps
`default_nettype none
module clock_output_control_tb_top;
  import clock_output_control_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mon, e;
  logic reference_pair_a, reference_pair_b, feedback_pair_a, feedback_pair_b, oscillator_clk, input_divider_clk;
  logic reference_select, feedback_select, bypass, loop_reset, sync_gate_input, global_output_disable;
  logic output_enable_x_n, output_enable_y_n, profile_select_bit0, profile_select_bit1;
  logic reference_clk, feedback_clk, feedback_buffer_en, lock_n;
  logic [1:0] active_profile;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [num_outputs-1:0] clock_out, clock_out_oe, out_slew;
  logic [num_banks*3-1:0] bank_driver_type;
  logic [num_outputs*4-1:0] out_impedance;
  int err_count, checked, run, bw, np;
  clock_output_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reference_pair_a, .reference_pair_b, .feedback_pair_a, .feedback_pair_b, .reference_select,
    .feedback_select, .oscillator_clk, .input_divider_clk, .bypass, .loop_reset, .sync_gate_input,
    .global_output_disable, .output_enable_x_n, .output_enable_y_n, .profile_select_bit0, .profile_select_bit1,
    .factory_test_input_1(1'b0), .factory_test_input_2(1'b0), .reference_clk, .feedback_clk,
    .feedback_buffer_en, .lock_n, .active_profile, .clock_out, .clock_out_oe, .bank_driver_type,
    .out_impedance, .out_slew);
  clock_source_model src_u (.pclk, .presetn, .reference_pair_a, .reference_pair_b, .feedback_pair_a,
    .feedback_pair_b, .oscillator_clk, .input_divider_clk);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_lock();
    for (int n = 0; n < 3000 && lock_n !== 1'b0; n++) @(negedge pclk);
    chk("lock_n", lock_n, 32'h0);
    @(posedge pclk);
  endtask
  ////////////////////////////////////////
  // Every high pulse of output 0 must be whole
  always @(negedge pclk) begin
    if (!mon) run = clock_out[0] ? -64 : 0;
    else if (clock_out[0]) run++;
    else begin
      if (run > 0) chk("pulse", run, bw);
      np += (run > 0);
      run = 0;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (10000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, mon, presetn, bypass, loop_reset, sync_gate_input, global_output_disable} = '0;
    {reference_select, feedback_select, profile_select_bit0, profile_select_bit1, paddr, pwdata} = '0;
    {output_enable_x_n, output_enable_y_n} = 2'h3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int s = 0; s < 9; s++) begin
      {reference_select, feedback_select, profile_select_bit1, profile_select_bit0} <= {s[2], s[2], s[1:0]};
      @(negedge pclk);
      chk("lock", lock_n, 32'h1);
      chk("ref", reference_clk, s[2] ? reference_pair_b : reference_pair_a);
      chk("fbk", feedback_clk, s[2] ? feedback_pair_b : feedback_pair_a);
      chk("profile", active_profile, s[1:0]);
      @(posedge pclk);
    end
    apb(1'b1, 12'h004, 32'h28);
    apb(1'b0, 12'h004, 32'h0);
    chk("bank1", q, 32'h28);
    chk("drv1", bank_driver_type[5:3], 32'h5);
    apb(1'b1, 12'h084, 32'h15);
    chk("imp", out_impedance[7:0], 32'h50);
    chk("slew", out_slew[1:0], 32'h2);
    apb(1'b0, 12'h800, 32'h0);
    chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h040, 32'h36);
    for (int k = 0; k < 2; k++) begin
      {output_enable_x_n, output_enable_y_n} <= {k[0], !k[0]};
      @(negedge pclk);
      chk("oe", clock_out_oe[3:0], k ? 32'hc : 32'h9);
      @(posedge pclk);
    end
    apb(1'b1, off_div_cfg + 12'h004, 32'h1);
    apb(1'b0, off_div_cfg + 12'h004, 32'h0);
    chk("div1", q, 32'h1);
    chk("imp16", out_impedance[67:64], 32'h0);
    apb(1'b1, 12'h000, 32'h41);
    repeat (8) @(negedge pclk);
    chk("gated", clock_out[0], 32'h0);
    @(posedge pclk);
    bw = 4;
    mon <= 1'b1;
    sync_gate_input <= 1'b1;
    repeat (64) @(posedge pclk);
    mon <= 1'b0;
    bypass <= 1'b1;
    bw = 8;
    repeat (16) @(posedge pclk);
    mon <= 1'b1;
    repeat (64) @(posedge pclk);
    sync_gate_input <= 1'b0;
    repeat (24) @(negedge pclk);
    chk("gated", {np > 7, clock_out[0]}, 32'h2);
    @(posedge pclk);
    bypass <= 1'b0;
    wait_lock();
    apb(1'b0, off_status, 32'h0);
    chk("status", q, 32'h1);
    global_output_disable <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("oe off", clock_out_oe, 32'h0);
    chk("fb buf", {feedback_buffer_en, lock_n}, 32'h1);
    @(posedge pclk);
    global_output_disable <= 1'b0;
    wait_lock();
    loop_reset <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("lock rst", lock_n, 32'h1);
    end_of_test();
  end
endmodule // clock_output_control_tb_top
`default_nettype wire
